// ==== inc/timing_index_data_timing_params.svh ====
// Constants of the timing controller: register indices, field positions,
// reset values and masks. Assumes nothing beyond being included by name.
`ifndef TIMING_INDEX_DATA_TIMING_PARAMS_SVH
`define TIMING_INDEX_DATA_TIMING_PARAMS_SVH

// Register indices reached through the index byte
`define IDX_HTOTAL 6'h00
`define IDX_HDISPEND 6'h01
`define IDX_HBLKSTR 6'h02
`define IDX_HBLKEND 6'h03
`define IDX_HSYNCSTR 6'h04
`define IDX_HSYNCEND 6'h05
`define IDX_VTOTAL 6'h06
`define IDX_OVERFLOW 6'h07
`define IDX_ROWPRESET 6'h08
`define IDX_MAXSCAN 6'h09
`define IDX_CURSTART 6'h0A
`define IDX_CUREND 6'h0B
`define IDX_LAST 6'h0B
`define IDX_PROT_LAST 6'h07

// Reset values
`define REG_RESET 8'h00
`define HBLKEND_RESET 8'h80

// Writable and readable bit masks
`define MASK_FULL 8'hFF
`define MASK_LOW7 8'h7F
`define MASK_LOW6 8'h3F
`define MASK_TOP 8'h80
`define MASK_LINECOMP 8'h10

// Field positions
`define SKEW_LSB 5
`define HBE5_POS 7
`define OVF_VT8 0
`define OVF_VT9 5
`define MSL_DBL 7
`define CUR_OFF 5

// Positions in the extension registers
`define HEXT_HT8 0
`define HEXT_HBS8 1
`define HEXT_HSS8 2
`define HEXT_HBE6 6
`define VEXT_VT10 0
`define VEXT_VT11 1

`endif

// ==== inc/timing_index_data_pkg.sv ====
// Types shared by the timing controller and its bench.
// Assumes the constants header is compiled alongside.
package timing_index_data_pkg;

    // One host access on the index/data port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] be;
        logic [15:0] wdata;
    } io_req_t;

    // Timing signals toward the display path
    typedef struct packed {
        logic disp_en;
        logic hblank;
        logic hsync;
        logic cursor;
    } timing_out_t;

    // Whole state of the controller
    typedef struct packed {
        logic [11:0][7:0] regs;
        logic [5:0] idx;
        logic [15:0] rdata;
        logic [8:0] hcnt;
        logic [11:0] vcnt;
        logic vhalf;
        logic dbl_half;
        logic [4:0] row;
        logic hde;
        logic hblank;
        logic hsync;
        logic cur;
        logic [2:0] de_sh;
        logic [2:0] hs_sh;
        logic [2:0] cur_sh;
        logic frame_p;
        logic row_p;
        timing_out_t out;
    } state_t;

endpackage

// ==== rtl/timing_index_data_timing.sv ====
// Timing controller: indexed timing registers, horizontal and vertical
// counters, display enable, blanking, sync, row scan and cursor rows.
// Assumes synchronous host strobes, extension bits and protect from outside.
//
// What this block does
// - 16-bit port: index in bits 5:0, selected register in upper data byte.
// - Unused indices ignore writes and read back as zero.
// - Horizontal total is nine bits: low byte here, bit 8 in extension.
// - Protect bit blocks writes to indices 0-7, except overflow line-compare bit.
// - Display enable drops when character counter equals display-end value.
// - Blanking ends when counter low six bits match the split blanking-end value.
// - Display-enable skew code delays display enable by 0 to 3 characters.
// - Top bit of blanking-end register ignores writes and reads as one.
// - Sync starts when counter equals nine-bit sync-start value.
// - Sync-delay code postpones horizontal sync by 0 to 3 characters.
// - Vertical total is twelve bits, in lines or line pairs.
// - Overflow register carries vertical total bits 8 and 9; bits 10 and 11 come from extension.
// - Row scan loads preset after retrace, clears at maximum row.
// - Maximum scan register holds row count and doubling.
// - Line doubling steps row scan and address reload every two lines.
// - Cursor-off bit set hides cursor, cleared shows it.
// - Cursor spans start row to end row; start above end shows none.
// - Cursor skew code delays cursor by 0 to 3 characters.
`include "timing_index_data_timing_params.svh"
`timescale 1ns/1ps
`default_nettype none

module timing_index_data_timing
    import timing_index_data_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Index/data port
    input wire io_req_t io_req_i,
    output logic [15:0] io_rdata_o,
    // Joined from neighbouring logic
    input wire logic [7:0] horiz_ext_i,
    input wire logic [7:0] vert_ext_i,
    input wire logic timing_protect_i,
    input wire logic vert_count_by2_i,
    // Toward display path
    output timing_out_t timing_o,
    output logic [8:0] hcount_o,
    output logic [11:0] vcount_o,
    output logic [4:0] row_scan_o,
    output logic frame_start_o,
    output logic row_addr_load_o
);

    state_t s_reg;
    state_t s_next;

    // Writable bits per index; reserved bits keep their stored value
    function automatic logic [7:0] wr_mask(input logic [5:0] idx);
        unique case (idx)
            `IDX_HBLKEND: wr_mask = `MASK_LOW7;
            `IDX_ROWPRESET: wr_mask = `MASK_LOW7;
            `IDX_CURSTART: wr_mask = `MASK_LOW6;
            `IDX_CUREND: wr_mask = `MASK_LOW7;
            default: wr_mask = `MASK_FULL;
        endcase
    endfunction

    // Field views of the register file
    logic [8:0] htotal;
    logic [8:0] hdispend;
    logic [8:0] hblkstr;
    logic [6:0] hblkend;
    logic [8:0] hsyncstr;
    logic [4:0] hsyncend;
    logic [11:0] vtotal;
    logic [4:0] preset;
    logic [4:0] maxscan;
    logic dbl;
    logic [4:0] cur_start;
    logic [4:0] cur_end;
    logic cur_off;
    logic [1:0] de_skew;
    logic [1:0] hs_del;
    logic [1:0] cur_skew;
    logic [5:0] idx;

    // High bits gathered from overflow, sync-end and extension registers
    assign idx = s_reg.idx;
    assign htotal = {horiz_ext_i[`HEXT_HT8], s_reg.regs[`IDX_HTOTAL]};
    assign hdispend = {1'b0, s_reg.regs[`IDX_HDISPEND]};
    assign hblkstr = {horiz_ext_i[`HEXT_HBS8], s_reg.regs[`IDX_HBLKSTR]};
    assign hblkend = {horiz_ext_i[`HEXT_HBE6], s_reg.regs[`IDX_HSYNCEND][`HBE5_POS],
                      s_reg.regs[`IDX_HBLKEND][4:0]};
    assign hsyncstr = {horiz_ext_i[`HEXT_HSS8], s_reg.regs[`IDX_HSYNCSTR]};
    assign hsyncend = s_reg.regs[`IDX_HSYNCEND][4:0];
    assign vtotal = {vert_ext_i[`VEXT_VT11], vert_ext_i[`VEXT_VT10],
                     s_reg.regs[`IDX_OVERFLOW][`OVF_VT9],
                     s_reg.regs[`IDX_OVERFLOW][`OVF_VT8],
                     s_reg.regs[`IDX_VTOTAL]};
    assign preset = s_reg.regs[`IDX_ROWPRESET][4:0];
    assign maxscan = s_reg.regs[`IDX_MAXSCAN][4:0];
    assign dbl = s_reg.regs[`IDX_MAXSCAN][`MSL_DBL];
    assign cur_start = s_reg.regs[`IDX_CURSTART][4:0];
    assign cur_end = s_reg.regs[`IDX_CUREND][4:0];
    assign cur_off = s_reg.regs[`IDX_CURSTART][`CUR_OFF];
    assign de_skew = s_reg.regs[`IDX_HBLKEND][`SKEW_LSB +: 2];
    assign hs_del = s_reg.regs[`IDX_HSYNCEND][`SKEW_LSB +: 2];
    assign cur_skew = s_reg.regs[`IDX_CUREND][`SKEW_LSB +: 2];

    // Next-state logic for registers, counters and timing
    always_comb begin
        logic [7:0] m;
        logic [7:0] rd_byte;
        logic line_end;
        logic vstep;
        logic frame_end;
        logic row_step;
        m = 8'h00;
        rd_byte = 8'h00;
        line_end = 1'b0;
        vstep = 1'b0;
        frame_end = 1'b0;
        row_step = 1'b0;
        s_next = s_reg;
        s_next.frame_p = 1'b0;
        s_next.row_p = 1'b0;

        // Data byte uses the index held before this access
        if (io_req_i.wr && io_req_i.be[1] && idx <= `IDX_LAST) begin
            m = wr_mask(idx);
            if (timing_protect_i && idx <= `IDX_PROT_LAST) begin
                m = (idx == `IDX_OVERFLOW) ? `MASK_LINECOMP : 8'h00;
            end
            s_next.regs[idx[3:0]] = (s_reg.regs[idx[3:0]] & ~m) | (io_req_i.wdata[15:8] & m);
        end
        if (io_req_i.wr && io_req_i.be[0]) begin
            s_next.idx = io_req_i.wdata[5:0];
        end

        // Read answer one edge after the strobe
        if (io_req_i.rd) begin
            if (idx <= `IDX_LAST) begin
                rd_byte = s_reg.regs[idx[3:0]] & wr_mask(idx);
                if (idx == `IDX_HBLKEND) begin
                    rd_byte = rd_byte | `MASK_TOP;
                end
            end
            s_next.rdata = {rd_byte, 2'b00, idx};
        end

        // Character counter and line stepping
        line_end = (s_reg.hcnt == htotal);
        s_next.hcnt = line_end ? 9'h000 : s_reg.hcnt + 9'h001;
        if (line_end) begin
            s_next.vhalf = vert_count_by2_i ? ~s_reg.vhalf : 1'b0;
            vstep = !vert_count_by2_i || s_reg.vhalf;
        end
        if (vstep) begin
            frame_end = (s_reg.vcnt == vtotal);
            s_next.vcnt = frame_end ? 12'h000 : s_reg.vcnt + 12'h001;
        end

        // Row scan: preset at frame start, otherwise step per line or pair
        if (frame_end) begin
            s_next.row = preset;
            s_next.dbl_half = 1'b0;
            s_next.frame_p = 1'b1;
        end else if (line_end) begin
            s_next.dbl_half = dbl ? ~s_reg.dbl_half : 1'b0;
            row_step = !dbl || s_reg.dbl_half;
        end
        if (row_step) begin
            if (s_reg.row == maxscan) begin
                s_next.row = 5'h00;
                s_next.row_p = 1'b1;
            end else begin
                s_next.row = s_reg.row + 5'h01;
            end
        end

        // Horizontal display enable: on at zero, off at display end
        if (line_end) begin
            s_next.hde = 1'b1;
        end else if (s_reg.hcnt == hdispend) begin
            s_next.hde = 1'b0;
        end

        // Blanking: start at full compare, end on six-bit match
        if (s_reg.hcnt == hblkstr) begin
            s_next.hblank = 1'b1;
        end else if (s_reg.hblank && s_reg.hcnt[5:0] == hblkend[5:0]) begin
            s_next.hblank = 1'b0;
        end

        // Sync: start at full compare, end on five-bit match
        if (s_reg.hcnt == hsyncstr) begin
            s_next.hsync = 1'b1;
        end else if (s_reg.hsync && s_reg.hcnt[4:0] == hsyncend) begin
            s_next.hsync = 1'b0;
        end

        // Cursor row window; empty when start lies past end
        s_next.cur = !cur_off && (cur_start <= cur_end) &&
                     (s_reg.row >= cur_start) && (s_reg.row <= cur_end);

        // Skew taps: tap n is the source delayed n more characters
        s_next.de_sh = {s_reg.de_sh[1:0], s_reg.hde};
        s_next.hs_sh = {s_reg.hs_sh[1:0], s_reg.hsync};
        s_next.cur_sh = {s_reg.cur_sh[1:0], s_reg.cur};
        s_next.out.disp_en = (de_skew == 2'b00) ? s_reg.hde : s_reg.de_sh[de_skew - 2'd1];
        s_next.out.hsync = (hs_del == 2'b00) ? s_reg.hsync : s_reg.hs_sh[hs_del - 2'd1];
        s_next.out.cursor = (cur_skew == 2'b00) ? s_reg.cur
                                                : s_reg.cur_sh[cur_skew - 2'd1];
        s_next.out.hblank = s_reg.hblank;
    end

    // Reset image of the state
    function automatic state_t reset_state();
        state_t r;
        r = '0;
        r.regs[`IDX_HBLKEND] = `HBLKEND_RESET;
        return r;
    endfunction

    // Single state register
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= reset_state();
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign io_rdata_o = s_reg.rdata;
    assign timing_o = s_reg.out;
    assign hcount_o = s_reg.hcnt;
    assign vcount_o = s_reg.vcnt;
    assign row_scan_o = s_reg.row;
    assign frame_start_o = s_reg.frame_p;
    assign row_addr_load_o = s_reg.row_p;

    // Checks on the state against its causes
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic wr_data;
    assign wr_data = io_req_i.wr && io_req_i.be[1];

    a_hcnt_wrap: assert property (
        s_reg.hcnt == htotal |=> s_reg.hcnt == 9'h000)
        else $error("character counter did not wrap at total");

    a_hde_end: assert property (
        s_reg.hcnt == hdispend && s_reg.hcnt != htotal |=> !s_reg.hde)
        else $error("display enable stayed on past display end");

    a_blank_end: assert property (
        s_reg.hblank && s_reg.hcnt != hblkstr && s_reg.hcnt[5:0] == hblkend[5:0]
        |=> !s_reg.hblank)
        else $error("blanking did not end on six-bit match");

    a_sync_window: assert property (
        s_reg.hcnt == hsyncstr |=> s_reg.hsync)
        else $error("sync did not start at sync-start value");

    a_sync_end: assert property (
        s_reg.hsync && s_reg.hcnt != hsyncstr && s_reg.hcnt[4:0] == hsyncend
        |=> !s_reg.hsync)
        else $error("sync did not end on five-bit match");

    a_protect_block: assert property (
        wr_data && timing_protect_i && idx < `IDX_OVERFLOW
        |=> s_reg.regs[$past(idx[3:0])] == $past(s_reg.regs[idx[3:0]]))
        else $error("protected register changed on write");

    a_unused_zero: assert property (
        io_req_i.rd && idx > `IDX_LAST |=> io_rdata_o[15:8] == 8'h00)
        else $error("unused index read not zero");

    a_hbe_top_one: assert property (
        io_req_i.rd && idx == `IDX_HBLKEND |=> io_rdata_o[15])
        else $error("blanking-end top bit read as zero");

    a_de_skew3: assert property (
        de_skew == 2'b11 && $stable(de_skew) [*5] |-> timing_o.disp_en == $past(s_reg.hde, 4))
        else $error("display enable skew of three wrong");

    a_row_clear: assert property (
        s_reg.hcnt == htotal && !dbl && s_reg.row == maxscan && !vert_count_by2_i
        && s_reg.vcnt != vtotal |=> s_reg.row == 5'h00 && row_addr_load_o)
        else $error("row scan did not clear at maximum row");

    a_cursor_off: assert property (
        cur_off [*6] |-> !timing_o.cursor)
        else $error("cursor shown while switched off");

    c_frame_wrap: cover property (frame_start_o);
    c_protected_write: cover property (wr_data && timing_protect_i && idx == `IDX_OVERFLOW);
    c_cursor_on: cover property (timing_o.cursor);
    c_doubled_row: cover property (dbl && row_addr_load_o);

endmodule

`default_nettype wire

// ==== test/timing_index_data_display_monitor.sv ====
// Display monitor model: measures the sync period and pulse widths.
// Assumes registered timing outputs from the controller on one clock.
`timescale 1ns/1ps
`default_nettype none
module timing_index_data_display_monitor
    import timing_index_data_pkg::*;
(
    // Clock and timing from the controller
    input wire logic core_clk_i,
    input wire timing_out_t timing_i,
    // Widths of sync, blank, enable and sync period, in characters
    output logic [2:0][15:0] width_o,
    output logic [15:0] period_o
);
    logic [2:0] sig;
    logic [2:0] prev = 3'h0;
    logic [2:0][15:0] run = '0;
    logic [15:0] since = 16'h0000;
    // Sync, blank, enable in slots 2..0
    assign sig = {timing_i.hsync, timing_i.hblank, timing_i.disp_en};
    // Run lengths latched on each fall; a monitor sees only the edges
    always @(posedge core_clk_i) begin
        prev <= sig;
        since <= (sig[2] && !prev[2]) ? 16'h0001 : since + 16'h0001;
        if (sig[2] && !prev[2]) begin
            period_o <= since;
        end
        for (int i = 0; i < 3; i++) begin
            run[i] <= sig[i] ? run[i] + 16'h0001 : 16'h0000;
            if (prev[i] && !sig[i]) begin
                width_o[i] <= run[i];
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/crt_timing_controller_regs_test.sv ====
// Bench for the timing controller: register port, protect, reset values,
// horizontal and vertical timing, skews, row scan and cursor rows.
// Assumes the package and the display monitor model are compiled first.
`include "timing_index_data_timing_params.svh"
`timescale 1ns/1ps
`default_nettype none
module crt_timing_controller_regs_test
    import timing_index_data_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    io_req_t io_req_i = '0;
    logic [7:0] horiz_ext_i = 8'h00;
    logic [7:0] vert_ext_i = 8'h00;
    logic timing_protect_i = 1'b0;
    logic vert_count_by2_i = 1'b0;
    logic [15:0] io_rdata_o;
    timing_out_t timing_o;
    logic [8:0] hcount_o;
    logic [11:0] vcount;
    logic [4:0] row_scan_o;
    logic frame_start_o;
    logic [2:0][15:0] width;
    logic [15:0] period;
    logic [7:0] shadow [12];
    logic [8:0] ht, hbs, hss;
    logic [7:0] hde;
    logic [6:0] hbe;
    logic [4:0] hse;
    logic [11:0] vt [6] = '{12'h005, 12'h005, 12'h102, 12'h201, 12'h401, 12'h800};
    logic [4:0] cs [3] = '{5'h01, 5'h03, 5'h00};
    logic [4:0] ce [3] = '{5'h02, 5'h01, 5'h03};
    logic [31:0] r;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 21652;
    int len, row;
    int pos [4];
    int base [4];

    // Design and the monitor on its timing outputs
    timing_index_data_timing dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .io_req_i(io_req_i),
        .io_rdata_o(io_rdata_o), .horiz_ext_i(horiz_ext_i), .vert_ext_i(vert_ext_i),
        .timing_protect_i(timing_protect_i), .vert_count_by2_i(vert_count_by2_i),
        .timing_o(timing_o), .hcount_o(hcount_o), .vcount_o(vcount), .row_scan_o(row_scan_o),
        .frame_start_o(frame_start_o), .row_addr_load_o());
    timing_index_data_display_monitor monitor (.core_clk_i(core_clk_i), .timing_i(timing_o),
        .width_o(width), .period_o(period));

    // 20 MHz character clock
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h got %h", what, exp, got);
        end
    endtask

    task automatic chk_count(input string what, input int exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp[15:0]) begin
            miscompares++;
            $display("ERROR %s expected %0d got %0d", what, exp, got);
        end
    endtask

    // One strobe, held over exactly one rising edge
    task automatic access(input logic w, input logic [1:0] be, input logic [15:0] d);
        @(negedge core_clk_i);
        io_req_i = '{wr: w, rd: !w, be: be, wdata: d};
        @(negedge core_clk_i);
        io_req_i = '0;
    endtask

    // Index byte then data byte; the model drops unused writes and protected ones except the overflow line-compare bit
    task automatic reg_wr(input logic [5:0] idx, input logic [7:0] d);
        access(1'b1, 2'b01, {10'h000, idx});
        access(1'b1, 2'b10, {d, 8'h00});
        if (idx <= `IDX_LAST && !(timing_protect_i && idx <= `IDX_PROT_LAST)) begin
            shadow[idx] = d;
        end else if (idx == `IDX_OVERFLOW) begin
            shadow[7] = (shadow[7] & ~`MASK_LINECOMP) | (d & `MASK_LINECOMP);
        end
    endtask

    function automatic logic [7:0] exp_read(input logic [5:0] idx);
        case (idx)
            `IDX_HBLKEND: return shadow[3] & `MASK_LOW7 | `MASK_TOP;
            `IDX_ROWPRESET, `IDX_CUREND: return shadow[idx] & `MASK_LOW7;
            `IDX_CURSTART: return shadow[idx] & `MASK_LOW6;
            default: return (idx <= `IDX_LAST) ? shadow[idx] : 8'h00;
        endcase
    endfunction

    task automatic reg_rd(input logic [5:0] idx);
        access(1'b1, 2'b01, {10'h000, idx});
        access(1'b0, 2'b00, 16'h0000);
        chk_byte("data", exp_read(idx), io_rdata_o[15:8]);
        chk_byte("index", {2'b00, idx}, io_rdata_o[7:0]);
    endtask

    // Characters from a start compare until the counter matches under a mask
    function automatic int steps(input int from, input int mask, input int tgt, input int tot);
        int h = from;
        for (int k = 1; k <= 600; k++) begin
            h = (h == tot) ? 0 : h + 1;
            if ((h & mask) == tgt) return k;
        end
        return 0;
    endfunction

    task automatic set_h(input logic [1:0] code);
        horiz_ext_i = {1'b0, hbe[6], 3'b000, hss[8], hbs[8], ht[8]};
        reg_wr(6'h00, ht[7:0]);
        reg_wr(6'h01, hde);
        reg_wr(6'h02, hbs[7:0]);
        reg_wr(6'h03, {1'b1, code, hbe[4:0]});
        reg_wr(6'h04, hss[7:0]);
        reg_wr(6'h05, {hbe[5], code, hse});
        reg_wr(6'h0B, {1'b0, code, 5'h01});
    endtask

    task automatic h_check();
        // Margin covers a counter that ran past a shortened total
        repeat (3 * (ht + 1) + 512) @(negedge core_clk_i);
        chk_count("line", ht + 1, period);
        chk_count("enable", hde + 1, width[0]);
        chk_count("blank", steps(hbs, 63, hbe & 63, ht), width[1]);
        chk_count("sync", steps(hss, 31, hse, ht), width[2]);
    endtask

    // Counter position at the next rise; -1 when none comes
    task automatic rise_pos(input int b, output int p);
        logic last = 1'b1;
        p = -1;
        for (int n = 0; n < 4000 && p < 0; n++) begin
            @(negedge core_clk_i);
            if (timing_o[b] === 1'b1 && last === 1'b0) p = hcount_o;
            last = timing_o[b];
        end
    endtask

    // First wait may straddle a setting change, so only the second counts
    task automatic frame_len(output int n);
        for (int p = 0; p < 2; p++) begin
            n = 0;
            do begin
                @(negedge core_clk_i);
                n++;
            end while (frame_start_o !== 1'b1 && n < 25000);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        for (int i = 0; i < 12; i++) shadow[i] = 8'h00;
        repeat (10) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 64; i++) reg_rd(i[5:0]);
        for (int n = 0; n < 120; n++) begin
            r = $random(seed);
            timing_protect_i = (r[17:16] == 2'b00);
            reg_wr({2'b00, r[3:0]}, r[15:8]);
            reg_rd({2'b00, r[23:20]});
        end
        timing_protect_i = 1'b0;
        reg_wr(6'h01, 8'h11);
        access(1'b1, 2'b11, 16'h2204);
        shadow[1] = 8'h22;
        reg_rd(6'h01);
        // Reset in mid-run restores every register
        rst_n_i = 1'b0;
        repeat (3) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 12; i++) shadow[i] = 8'h00;
        for (int i = 0; i < 12; i++) reg_rd(i[5:0]);
        {ht, hbs, hss, hde, hbe, hse} = {9'h104, 9'h0F0, 9'h100, 8'h80, 7'h41, 5'h03};
        set_h(2'b00);
        h_check();
        {ht, hbs, hss, hde, hbe, hse} = {9'h04F, 9'h042, 9'h045, 8'h3F, 7'h2A, 5'h08};
        set_h(2'b00);
        h_check();
        // Row scan and cursor window, line by line over one frame
        reg_wr(6'h06, 8'h0B);
        reg_wr(6'h08, 8'h02);
        for (int c = 0; c < 3; c++) begin
            reg_wr(6'h09, {c == 1, 7'h03});
            reg_wr(6'h0A, {2'b00, c == 2, cs[c]});
            reg_wr(6'h0B, {3'b000, ce[c]});
            frame_len(len);
            for (int k = 0; k < 12; k++) begin
                do @(negedge core_clk_i); while (hcount_o !== 9'h005);
                row = 2;
                for (int j = 0; j < k / (c == 1 ? 2 : 1); j++) row = (row == 3) ? 0 : row + 1;
                chk_byte("row", row[7:0], {3'b000, row_scan_o});
                chk_count("vcount", k, {4'h0, vcount});
                chk_byte("cursor", {7'h00, c != 2 && cs[c] <= ce[c] && row >= cs[c]
                    && row <= ce[c]}, {7'h00, timing_o.cursor});
            end
        end
        // Every skew code against the code-0 positions
        reg_wr(6'h09, 8'h03);
        reg_wr(6'h0A, 8'h01);
        for (int code = 0; code < 4; code++) begin
            set_h(code[1:0]);
            for (int b = 0; b < 4; b++) begin
                if (b == 2) continue;
                rise_pos(b, pos[b]);
                rise_pos(b, pos[b]);
                if (code == 0) base[b] = pos[b];
                chk_count("skew", base[b] + code, pos[b][15:0]);
            end
        end
        chk_count("sync start", base[3] + hss + 1, base[1][15:0]);
        // Vertical totals through overflow and extension bits
        reg_wr(6'h00, 8'h04);
        for (int i = 0; i < 6; i++) begin
            vert_count_by2_i = (i == 1);
            vert_ext_i = {6'h00, vt[i][11:10]};
            reg_wr(6'h07, {2'b00, vt[i][9], 4'h0, vt[i][8]});
            reg_wr(6'h06, vt[i][7:0]);
            frame_len(len);
            chk_count("frame", (vt[i] + 1) * 5 * (i == 1 ? 2 : 1), len[15:0]);
        end
        wrap_up();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (95000) @(negedge core_clk_i);
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
